// [hw/transceiver_status_alarm_regs.v]
// Operation
// RULE1 - bit 7 high while shutdown gate active
// RULE2 - polarity input sets pin level, not flag
// RULE3 - bit 6 forces shutdown and disables outputs
// RULE4 - bit 4 resets fault latch, self clears
// RULE5 - internal disable is bit 3 OR pin
// RULE6 - bit 2 mirrors fault pin, read only
// RULE7 - bit 1 mirrors signal loss input
// RULE8 - bit 0 high when supply not ready
// RULE9 - eight ready flags, temperature at bit 7
// RULE10 - ready flags reset zero, set on completion
// RULE11 - host write clears ready flags
// RULE12 - temperature high alarm above threshold
// RULE13 - temperature low alarm below threshold
// RULE14 - supply high alarm above threshold
// RULE15 - supply low resets one, follows trip level
// RULE16 - monitor one high and low alarms
// RULE17 - monitor two high and low alarms
// RULE18 - temperature signed, others unsigned, every update
// RULE19 - read-only bits and alarm ignore writes
// RULE20 - host ignores pin mirrors at power on
`timescale 1ns/1ns
`include "transceiver_status_alarm_defines.vh"
module transceiver_status_alarm_regs (
    input wire sys_clk,
    input wire rst,
    input wire [7:0] regAddr,
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regWdata,
    output reg [7:0] regRdata,
    output reg regRvalid,
    input wire txDisablePin,
    input wire faultDetect,
    input wire shutdownRequest,
    input wire shutdown_gate_polarity,
    input wire signal_loss_input,
    input wire supplyBelowTrip,
    input wire supplyTooLowForBus,
    input wire [7:0] convDone,
    input wire [15:0] tempValue,
    input wire [15:0] supplyValue,
    input wire [15:0] monOneValue,
    input wire [15:0] monTwoValue,
    input wire [15:0] tempHighThreshold,
    input wire [15:0] tempLowThreshold,
    input wire [15:0] supplyHighThreshold,
    input wire [15:0] supplyLowThreshold,
    input wire [15:0] monOneHighThreshold,
    input wire [15:0] monOneLowThreshold,
    input wire [15:0] monTwoHighThreshold,
    input wire [15:0] monTwoLowThreshold,
    output reg fast_shutdown_gate_out,
    output reg biasModEnable,
    output reg txDisableInternal,
    output reg txFaultOut
);
    // host-writable control bits
    reg software_shutdown_force;
    reg faultLatchReset;
    reg softTxDisable;

    // hardware status bits
    reg shutdown_gate_active_flag;
    reg signal_loss_flag;
    reg not_ready_flag;

    wire writeStatus;
    wire writeReady;
    wire [7:0] readyFlags;
    wire [7:0] alarmFlags;
    wire [7:0] statusValue;
    wire nextGateActive;
    wire nextTxDisable;

    reg [7:0] next_rdata;

    assign writeStatus = regWrite && (regAddr == `OFS_PIN_STATUS_CONTROL);
    assign writeReady = regWrite && (regAddr == `OFS_CONVERSION_READY);

    // gate active from software force, fault latch or external request
    assign nextGateActive = software_shutdown_force | txFaultOut
        | shutdownRequest; // see RULE3
    assign nextTxDisable = softTxDisable | txDisablePin; // see RULE5

    // control bits; writes to bits 7, 5, 2, 1, 0 are dropped
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            software_shutdown_force <= `RST_CONTROL_BITS;
            softTxDisable <= `RST_CONTROL_BITS;
        end else if (writeStatus) begin
            software_shutdown_force <=
                regWdata[`BIT_SOFT_SHUTDOWN]; // see RULE3
            softTxDisable <= regWdata[`BIT_SOFT_TX_DISABLE]; // see RULE19
        end
    end

    // latch reset request clears itself once the fault input is low, on the same edge that resets the latch
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            faultLatchReset <= `RST_CONTROL_BITS;
        end else if (writeStatus && regWdata[`BIT_FAULT_LATCH_RESET]) begin
            faultLatchReset <= 1'b1; // see RULE4
        end else if (faultLatchReset && !faultDetect) begin
            faultLatchReset <= 1'b0; // see RULE4
        end
    end

    // transmit fault latch; a new fault wins over the reset
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            txFaultOut <= 1'b0;
        end else if (faultDetect) begin
            txFaultOut <= 1'b1;
        end else if (faultLatchReset) begin
            txFaultOut <= 1'b0; // see RULE4
        end
    end

    // shutdown gate, transmit disable and output enable
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shutdown_gate_active_flag <= 1'b0;
            fast_shutdown_gate_out <= 1'b0;
            biasModEnable <= 1'b0;
            txDisableInternal <= 1'b0;
        end else begin
            shutdown_gate_active_flag <= nextGateActive; // see RULE1
            fast_shutdown_gate_out <= shutdown_gate_polarity ?
                nextGateActive : !nextGateActive; // see RULE2
            biasModEnable <= !nextGateActive && !nextTxDisable; // see RULE3
            txDisableInternal <= nextTxDisable; // see RULE5
        end
    end

    // pin and supply mirrors
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            signal_loss_flag <= 1'b0;
            not_ready_flag <= 1'b1;
        end else begin
            signal_loss_flag <= signal_loss_input; // see RULE7
            not_ready_flag <= supplyBelowTrip
                | supplyTooLowForBus; // see RULE8
        end
    end

    // completion flags
    conversion_ready_flags readyBank (
        .sys_clk(sys_clk),
        .rst(rst),
        .convDone(convDone), // see RULE9
        .hostWrite(writeReady), // see RULE11
        .hostData(regWdata),
        .flags(readyFlags)
    );

    // alarm comparators for temperature, supply, monitor one and monitor two only
    threshold_alarm #(
        .IS_SIGNED(1),
        .LOW_RESET(1'b0)
    ) tempAlarm (
        .sys_clk(sys_clk),
        .rst(rst),
        .update(convDone[`BIT_RDY_TEMP]), // see RULE18
        .value(tempValue),
        .highThreshold(tempHighThreshold),
        .lowThreshold(tempLowThreshold),
        .forceLow(1'b0),
        .highFlag(alarmFlags[`BIT_TEMP_HIGH]), // see RULE12
        .lowFlag(alarmFlags[`BIT_TEMP_LOW]) // see RULE13
    );

    threshold_alarm #(
        .IS_SIGNED(0),
        .LOW_RESET(1'b1)
    ) supplyAlarm (
        .sys_clk(sys_clk),
        .rst(rst),
        .update(convDone[`BIT_RDY_SUPPLY]), // see RULE18
        .value(supplyValue),
        .highThreshold(supplyHighThreshold),
        .lowThreshold(supplyLowThreshold),
        .forceLow(supplyBelowTrip), // see RULE15
        .highFlag(alarmFlags[`BIT_SUPPLY_HIGH]), // see RULE14
        .lowFlag(alarmFlags[`BIT_SUPPLY_LOW]) // see RULE15
    );

    threshold_alarm #(
        .IS_SIGNED(0),
        .LOW_RESET(1'b0)
    ) monOneAlarm (
        .sys_clk(sys_clk),
        .rst(rst),
        .update(convDone[`BIT_RDY_MON_ONE]),
        .value(monOneValue),
        .highThreshold(monOneHighThreshold),
        .lowThreshold(monOneLowThreshold),
        .forceLow(1'b0),
        .highFlag(alarmFlags[`BIT_MON_ONE_HIGH]), // see RULE16
        .lowFlag(alarmFlags[`BIT_MON_ONE_LOW]) // see RULE16
    );

    threshold_alarm #(
        .IS_SIGNED(0),
        .LOW_RESET(1'b0)
    ) monTwoAlarm (
        .sys_clk(sys_clk),
        .rst(rst),
        .update(convDone[`BIT_RDY_MON_TWO]),
        .value(monTwoValue),
        .highThreshold(monTwoHighThreshold),
        .lowThreshold(monTwoLowThreshold),
        .forceLow(1'b0),
        .highFlag(alarmFlags[`BIT_MON_TWO_HIGH]), // see RULE17
        .lowFlag(alarmFlags[`BIT_MON_TWO_LOW]) // see RULE17
    );

    // status read image; reserved bit reads zero
    assign statusValue = {
        shutdown_gate_active_flag,
        software_shutdown_force,
        1'b0,
        faultLatchReset,
        softTxDisable,
        txFaultOut, // see RULE6
        signal_loss_flag,
        not_ready_flag
    };

    // read mux; alarm register has no write path
    always @* begin
        case (regAddr)
            `OFS_PIN_STATUS_CONTROL: next_rdata = statusValue;
            `OFS_CONVERSION_READY: next_rdata = readyFlags;
            `OFS_ALARM_TEMP_SUPPLY: next_rdata = alarmFlags; // see RULE19
            default: next_rdata = `RST_READ_DATA;
        endcase
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            regRdata <= `RST_READ_DATA;
            regRvalid <= 1'b0;
        end else begin
            regRvalid <= regRead;
            if (regRead) begin
                regRdata <= next_rdata;
            end
        end
    end
endmodule

// [hw/transceiver_status_alarm_defines.vh]
`ifndef TRANSCEIVER_STATUS_ALARM_DEFINES_VH
`define TRANSCEIVER_STATUS_ALARM_DEFINES_VH

// register offsets
`define OFS_PIN_STATUS_CONTROL 8'h6e
`define OFS_CONVERSION_READY 8'h6f
`define OFS_ALARM_TEMP_SUPPLY 8'h70

// pin status and control fields
`define BIT_SHUTDOWN_ACTIVE 7
`define BIT_SOFT_SHUTDOWN 6
`define BIT_RESERVED_FIVE 5
`define BIT_FAULT_LATCH_RESET 4
`define BIT_SOFT_TX_DISABLE 3
`define BIT_FAULT_STATUS 2
`define BIT_SIGNAL_LOSS 1
`define BIT_NOT_READY 0

// conversion ready fields, one per channel
`define BIT_RDY_TEMP 7
`define BIT_RDY_SUPPLY 6
`define BIT_RDY_MON_ONE 5
`define BIT_RDY_MON_TWO 4
`define BIT_RDY_MON_THREE 3
`define BIT_RDY_MON_FOUR 2
`define BIT_RDY_MON_FIVE_SEVEN 1
`define BIT_RDY_MON_SIX_EIGHT 0

// alarm fields
`define BIT_TEMP_HIGH 7
`define BIT_TEMP_LOW 6
`define BIT_SUPPLY_HIGH 5
`define BIT_SUPPLY_LOW 4
`define BIT_MON_ONE_HIGH 3
`define BIT_MON_ONE_LOW 2
`define BIT_MON_TWO_HIGH 1
`define BIT_MON_TWO_LOW 0

// reset values
`define RST_CONTROL_BITS 1'b0
`define RST_CONVERSION_READY 8'h00
`define RST_ALARM 8'h10
`define RST_READ_DATA 8'h00

`endif

// [hw/threshold_alarm.v]
`timescale 1ns/1ns
// one measured channel: high and low alarm flags updated per measurement
module threshold_alarm #(
    parameter IS_SIGNED = 0,
    parameter LOW_RESET = 1'b0
) (
    input wire sys_clk,
    input wire rst,
    input wire update,
    input wire [15:0] value,
    input wire [15:0] highThreshold,
    input wire [15:0] lowThreshold,
    input wire forceLow,
    output reg highFlag,
    output reg lowFlag
);
    wire aboveHigh;
    wire belowLow;

    // temperature compares signed, the others unsigned
    assign aboveHigh = IS_SIGNED ?
        ($signed(value) > $signed(highThreshold)) : (value > highThreshold);
    assign belowLow = IS_SIGNED ?
        ($signed(value) < $signed(lowThreshold)) : (value < lowThreshold);

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            highFlag <= 1'b0;
            lowFlag <= LOW_RESET;
        end else begin
            if (update) begin
                highFlag <= aboveHigh;
            end
            if (forceLow) begin
                lowFlag <= 1'b1;
            end else if (update) begin
                lowFlag <= belowLow;
            end
        end
    end
endmodule

// [hw/conversion_ready_flags.v]
`timescale 1ns/1ns
`include "transceiver_status_alarm_defines.vh"
// per-channel completion flags, set by hardware, cleared by host writes
module conversion_ready_flags (
    input wire sys_clk,
    input wire rst,
    input wire [7:0] convDone,
    input wire hostWrite,
    input wire [7:0] hostData,
    output wire [7:0] flags
);
    localparam [7:0] RESET_FLAGS = `RST_CONVERSION_READY;

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : chan
            reg flagBit;

            assign flags[i] = flagBit;

            always @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    flagBit <= RESET_FLAGS[i]; // see RULE10
                end else if (convDone[i]) begin
                    flagBit <= 1'b1; // see RULE10
                end else if (hostWrite && !hostData[i]) begin
                    flagBit <= 1'b0; // see RULE11
                end
            end
        end
    endgenerate
endmodule

// [dv/transceiver_status_alarm_checker.sv]
`timescale 1ns/1ns
module transceiver_status_alarm_checker (
    input wire sys_clk,
    input wire rst,
    input wire [7:0] regAddr,
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regWdata,
    input wire [7:0] regRdata,
    input wire regRvalid,
    input wire txDisablePin,
    input wire faultDetect,
    input wire shutdownRequest,
    input wire shutdown_gate_polarity,
    input wire [7:0] convDone,
    input wire [15:0] tempValue,
    input wire [15:0] tempHighThreshold,
    input wire fast_shutdown_gate_out,
    input wire biasModEnable,
    input wire txDisableInternal,
    input wire txFaultOut
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    read_answer_a: assert property (regRead |=> regRvalid)
        else $error("read not answered after one cycle");
    unmapped_zero_a: assert property (
        regRead && regAddr == 8'h71 |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    soft_force_a: assert property (
        regWrite && regAddr == 8'h6e && regWdata[6] |=> ##1 (!biasModEnable
        && fast_shutdown_gate_out == $past(shutdown_gate_polarity)))
        else $error("software force did not shut down");
    request_gate_a: assert property (shutdownRequest |=>
        !biasModEnable
        && fast_shutdown_gate_out == $past(shutdown_gate_polarity))
        else $error("shutdown request did not drive gate");
    tx_disable_a: assert property (
        txDisablePin |=> txDisableInternal)
        else $error("internal disable does not follow pin");
    fault_latch_a: assert property (faultDetect |=> txFaultOut)
        else $error("fault not latched");
    ready_set_a: assert property (convDone[7] ##1 !regWrite ##1
        (regRead && regAddr == 8'h6f) |=> regRdata[7])
        else $error("ready flag not set on completion");
    temp_high_a: assert property (convDone[7] &&
        $signed(tempValue) > $signed(tempHighThreshold) ##1 !convDone[7] ##1
        (regRead && regAddr == 8'h70) |=> regRdata[7])
        else $error("temperature high alarm missing");
endmodule
bind transceiver_status_alarm_regs transceiver_status_alarm_checker chk (
    .sys_clk, .rst, .regAddr, .regWrite, .regRead, .regWdata, .regRdata,
    .regRvalid, .txDisablePin, .faultDetect, .shutdownRequest,
    .shutdown_gate_polarity, .convDone, .tempValue, .tempHighThreshold,
    .fast_shutdown_gate_out, .biasModEnable, .txDisableInternal, .txFaultOut);

// [dv/host_model.sv]
`timescale 1ns/1ns
module host_model (
    input wire sys_clk,
    input wire [7:0] regRdata,
    input wire regRvalid,
    output reg [7:0] regAddr,
    output reg regWrite,
    output reg regRead,
    output reg [7:0] regWdata
);
    initial begin
        regAddr = 8'h00;
        regWrite = 0;
        regRead = 0;
        regWdata = 8'h00;
    end
    // single byte write, clearing ready flags is a write of zeros
    task wr(input [7:0] a, d);
        @(posedge sys_clk);
        #1;
        regAddr = a;
        regWdata = d;
        regWrite = 1;
        @(posedge sys_clk);
        #1 regWrite = 0;
        regWdata = ~d;
    endtask
    // pin mirrors are only read once the device has sampled them
    task rd(input [7:0] a, output [7:0] d);
        @(posedge sys_clk);
        #1;
        regAddr = a;
        regRead = 1;
        @(posedge sys_clk);
        #1 regRead = 0;
        d = regRvalid === 1'b1 ? regRdata : 8'hxx;
    endtask
endmodule

// [dv/transceiver_status_alarm_regs_tb.sv]
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module transceiver_status_alarm_regs_tb;
    reg sys_clk = 0, rst = 1;
    reg txDisablePin = 0, faultDetect = 0, shutdownRequest = 0;
    reg shutdown_gate_polarity = 1, signal_loss_input = 1;
    reg supplyBelowTrip = 0, supplyTooLowForBus = 0;
    reg [7:0] convDone = 8'h00;
    reg [15:0] tempValue = 16'h0000, supplyValue = 16'h0000;
    reg [15:0] monOneValue = 16'h0000, monTwoValue = 16'h0000;
    reg [15:0] tempHighThreshold = 16'h1900, tempLowThreshold = 16'hf600;
    reg [15:0] supplyHighThreshold = 16'hd000, supplyLowThreshold = 16'h8000;
    reg [15:0] monOneHighThreshold = 16'hc000, monOneLowThreshold = 16'h2000;
    reg [15:0] monTwoHighThreshold = 16'hc000, monTwoLowThreshold = 16'h2000;
    wire [7:0] regAddr, regWdata, regRdata;
    wire regWrite, regRead, regRvalid, fast_shutdown_gate_out;
    wire biasModEnable, txDisableInternal, txFaultOut;
    reg [71:0] tbl [0:2];
    int n_mismatch = 0, n_tests = 0;
    always #50 sys_clk = ~sys_clk;
    host_model host (.sys_clk, .regRdata, .regRvalid, .regAddr, .regWrite,
        .regRead, .regWdata);
    transceiver_status_alarm_regs DUT (.sys_clk, .rst, .regAddr, .regWrite,
        .regRead, .regWdata, .regRdata, .regRvalid, .txDisablePin,
        .faultDetect, .shutdownRequest, .shutdown_gate_polarity,
        .signal_loss_input, .supplyBelowTrip, .supplyTooLowForBus, .convDone,
        .tempValue, .supplyValue, .monOneValue, .monTwoValue,
        .tempHighThreshold, .tempLowThreshold, .supplyHighThreshold,
        .supplyLowThreshold, .monOneHighThreshold, .monOneLowThreshold,
        .monTwoHighThreshold, .monTwoLowThreshold, .fast_shutdown_gate_out,
        .biasModEnable, .txDisableInternal, .txFaultOut);
    task complete_run;
        if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task rdc(input [7:0] a, exp);
        reg [7:0] d;
        host.rd(a, d);
        `CHK($sformatf("reg %h", a), exp, d)
    endtask
    initial begin
        #100000;
        n_mismatch++;
        $display("mismatch watchdog exp done got hang");
        complete_run;
    end
    initial begin
        tbl[0] = 72'h1a00_7fff_c001_1fff_99;
        tbl[1] = 72'hf500_8000_c000_2000_40;
        tbl[2] = 72'h1900_d001_1fff_c001_26;
        repeat (2) @(posedge sys_clk);
        #1 rst = 0;
        rdc(8'h6f, 8'h00);
        rdc(8'h70, 8'h10);
        rdc(8'h6e, 8'h02);
        supplyTooLowForBus = 1;
        rdc(8'h6e, 8'h03);
        supplyTooLowForBus = 0;
        host.wr(8'h6e, 8'hea);
        idle(1);
        rdc(8'h6e, 8'hca);
        `CHK("bias", 1'b0, biasModEnable)
        `CHK("gate", 1'b1, fast_shutdown_gate_out)
        `CHK("txdis", 1'b1, txDisableInternal)
        shutdown_gate_polarity = 0;
        idle(1);
        `CHK("gate", 1'b0, fast_shutdown_gate_out)
        host.wr(8'h6e, 8'h00);
        idle(2);
        rdc(8'h6e, 8'h02);
        `CHK("gate", 1'b1, fast_shutdown_gate_out)
        `CHK("bias", 1'b1, biasModEnable)
        txDisablePin = 1;
        idle(2);
        `CHK("txdis", 1'b1, txDisableInternal)
        txDisablePin = 0;
        shutdownRequest = 1;
        idle(1);
        shutdownRequest = 0;
        faultDetect = 1;
        idle(1);
        faultDetect = 0;
        idle(3);
        rdc(8'h6e, 8'h86);
        faultDetect = 1;
        host.wr(8'h6e, 8'h10);
        rdc(8'h6e, 8'h96);
        faultDetect = 0;
        idle(4);
        rdc(8'h6e, 8'h02);
        `CHK("fault", 1'b0, txFaultOut)
        for (int i = 0; i < 3; i++) begin
            {tempValue, supplyValue, monOneValue, monTwoValue} = tbl[i][71:8];
            convDone = 8'hff;
            idle(1);
            convDone = 8'h00;
            rdc(8'h70, tbl[i][7:0]);
        end
        rdc(8'h6f, 8'hff);
        host.wr(8'h6f, 8'h0f);
        rdc(8'h6f, 8'h0f);
        convDone = 8'h80;
        idle(1);
        convDone = 8'h00;
        rdc(8'h6f, 8'h8f);
        host.wr(8'h70, 8'h00);
        rdc(8'h70, 8'h26);
        supplyBelowTrip = 1;
        idle(2);
        rdc(8'h70, 8'h36);
        rdc(8'h6e, 8'h03);
        rdc(8'h71, 8'h00);
        complete_run;
    end
endmodule
